// File: shared/flash_pins_pkg.sv
// constants, types and decoders for the flash pin-state controller
// Behaviour
// - instruction bits on line 0; outputs float
// - single input on line 0; outputs float
// - single latency ignores inputs, no drive
// - single output drives serial_out with data
// - dual latency lines ignored, never driven
// - dual output drives lines 0 and 1
// - quad page address only on line 0
// - quad latency ignores all four lines
// - quad output drives all four lines
// - line 3 selectable as reset or pause
// - select high means standby, reset only
// - pause low freezes command outside quad mode, outputs float
package flash_pins_pkg;

    // ---------------------------------------------------------------
    // sizes and pin positions
    // ---------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int LINES = 4;
    localparam int CNT_W = 6;
    localparam int LAT_W = 5;
    localparam int SYNC_W = 6;
    localparam int PAUSE_LINE = 3;
    localparam logic [3:0] BYTE_FULL = 4'h8;
    localparam logic [3:0] BITS_NONE = 4'h0;
    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'h2; // serial_out is data line 1
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hF;
    // reset value of the synchronised {sck, select_n, data lines}
    localparam logic [SYNC_W-1:0] SYNC_INIT = 6'h1F;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_STANDBY = 3'h0,
        PH_INSTR = 3'h1,
        PH_ADDR = 3'h3,
        PH_LATENCY = 3'h2,
        PH_DATA_OUT = 3'h6,
        PH_DATA_IN = 3'h7,
        PH_DONE = 3'h5
    } phase_t;

    typedef enum logic [1:0] {
        W_SINGLE = 2'h0,
        W_DUAL = 2'h1,
        W_QUAD = 2'h2,
        W_QPP = 2'h3
    } width_t;

    typedef enum logic [1:0] {
        DIR_NONE = 2'h0,
        DIR_IN = 2'h1,
        DIR_OUT = 2'h2
    } dir_t;

    typedef struct packed {
        width_t addr_w;
        logic [CNT_W-1:0] addr_cycles;
        logic [LAT_W-1:0] latency;
        dir_t dir;
        width_t data_w;
    } plan_t;

    typedef struct packed {
        logic [BYTE_BITS-1:0] data;
        logic is_addr;
    } rx_t;

    typedef struct packed {
        logic [LINES-1:0] out;
        logic [LINES-1:0] oe;
    } pins_t;

    // ---------------------------------------------------------------
    // width decoders
    // ---------------------------------------------------------------
    // bits moved per clock edge; quad page address counts as single
    function automatic logic [3:0] lanes(input width_t w);
        case (w)
            W_DUAL: lanes = 4'h2;
            W_QUAD: lanes = 4'h4;
            default: lanes = 4'h1;
        endcase
    endfunction : lanes

    function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                            input logic [3:0] d,
                                            input width_t w);
        case (w)
            W_DUAL: shift_in = {sh[5:0], d[1:0]};
            W_QUAD: shift_in = {sh[3:0], d};
            default: shift_in = {sh[6:0], d[0]}; // line 0 only
        endcase
    endfunction : shift_in

    function automatic logic [7:0] shift_out(input logic [7:0] sh,
                                             input width_t w);
        case (w)
            W_DUAL: shift_out = {sh[5:0], 2'h0};
            W_QUAD: shift_out = {sh[3:0], 4'h0};
            default: shift_out = {sh[6:0], 1'h0};
        endcase
    endfunction : shift_out

    // most significant bits first, lowest bit of a dual or quad group on line 0
    function automatic logic [3:0] out_bits(input logic [7:0] sh,
                                            input width_t w);
        case (w)
            W_DUAL: out_bits = {2'h0, sh[7:6]};
            W_QUAD: out_bits = sh[7:4];
            default: out_bits = {2'h0, sh[7], 1'h0};
        endcase
    endfunction : out_bits

    function automatic logic [3:0] oe_mask(input width_t w);
        case (w)
            W_DUAL: oe_mask = OE_DUAL;
            W_QUAD: oe_mask = OE_QUAD;
            default: oe_mask = OE_SINGLE;
        endcase
    endfunction : oe_mask

    function automatic phase_t data_phase(input plan_t p);
        case (p.dir)
            DIR_OUT: data_phase = PH_DATA_OUT;
            DIR_IN: data_phase = PH_DATA_IN;
            default: data_phase = PH_DONE;
        endcase
    endfunction : data_phase

endpackage : flash_pins_pkg

// File: rtl/pin_sync.sv
// three-stage input synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import flash_pins_pkg::*;
#(
    parameter int WIDTH = SYNC_W,
    parameter logic [WIDTH-1:0] INIT = SYNC_INIT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pins and filtered levels
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // synchroniser chain; s1 is read only by s2
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end
        else
        begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts once the second and third stages agree
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_agree
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                level[i] <= INIT[i];
            else if (s2[i] == s3[i])
                level[i] <= s2[i];
        end
    end

endmodule : pin_sync
`default_nettype wire

// File: rtl/flash_pin_state.sv
// pin direction and drive control of a multi-line serial flash interface
`timescale 1ns/1ps
`default_nettype none
module flash_pin_state
    import flash_pins_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic sck,
    input wire logic select_n,
    input wire logic [LINES-1:0] dq_in,
    output pins_t dq,
    // configuration straps
    input wire logic quad_mode,
    input wire logic io3_is_reset,
    // command side
    output logic [BYTE_BITS-1:0] instr,
    output logic instr_valid,
    input wire plan_t plan,
    output rx_t rx,
    output logic rx_valid,
    input wire logic [BYTE_BITS-1:0] tx_data,
    output logic tx_take,
    // status
    output phase_t phase,
    output logic paused,
    output logic warm_reset
);

    // ---------------------------------------------------------------
    // pin sampling and edge detection
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] filt;
    logic sck_f;
    logic sel_f;
    logic [LINES-1:0] d_f;
    logic sck_q;
    logic hold_now;
    logic warm_now;
    logic active;
    logic rise_ok;
    logic fall_ok;

    pin_sync #(
        .WIDTH(SYNC_W),
        .INIT(SYNC_INIT)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .raw({sck, select_n, dq_in}),
        .level(filt)
    );

    assign sck_f = filt[5];
    assign sel_f = filt[4];
    assign d_f = filt[3:0];

    // previous filtered clock level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sck_q <= 1'h0;
        else
            sck_q <= sck_f;
    end

    // line 3 acts as pause outside quad mode or as reset, depending on the strap
    assign hold_now = ~io3_is_reset & ~quad_mode & ~sel_f
                      & ~d_f[PAUSE_LINE];
    // quad mode honours the reset line only while deselected
    assign warm_now = io3_is_reset & ~d_f[PAUSE_LINE]
                      & (~quad_mode | sel_f);
    assign active = ~sel_f & ~warm_now;
    assign rise_ok = sck_f & ~sck_q & active & ~hold_now;
    assign fall_ok = ~sck_f & sck_q & active & ~hold_now;

    // ---------------------------------------------------------------
    // phase sequencer
    // ---------------------------------------------------------------
    plan_t plan_q;
    logic [CNT_W-1:0] cnt;
    phase_t after_addr;
    phase_t after_instr;

    // next phase once the address cycles are spent
    always_comb
    begin
        if (plan_q.latency != '0)
            after_addr = PH_LATENCY;
        else
            after_addr = data_phase(plan_q);
    end

    // next phase once the instruction byte is in
    always_comb
    begin
        if (plan.addr_cycles != '0)
            after_instr = PH_ADDR;
        else if (plan.latency != '0)
            after_instr = PH_LATENCY;
        else
            after_instr = data_phase(plan);
    end

    // phase register, cycle counter and latched plan
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase <= PH_STANDBY;
            cnt <= '0;
            plan_q <= '0;
        end
        else if (!active)
        begin
            phase <= PH_STANDBY;
            cnt <= '0;
        end
        else
        begin
            case (phase)
                PH_STANDBY:
                    phase <= PH_INSTR;
                PH_INSTR:
                    if (instr_valid)
                    begin
                        plan_q <= plan;
                        phase <= after_instr;
                        if (plan.addr_cycles != '0)
                            cnt <= plan.addr_cycles;
                        else
                            cnt <= CNT_W'(plan.latency);
                    end
                PH_ADDR:
                    if (rise_ok)
                    begin
                        cnt <= cnt - 1'h1;
                        if (cnt == CNT_W'(1))
                        begin
                            phase <= after_addr;
                            cnt <= CNT_W'(plan_q.latency);
                        end
                    end
                PH_LATENCY:
                    // latency cycles carry no data
                    if (rise_ok)
                    begin
                        cnt <= cnt - 1'h1;
                        if (cnt == CNT_W'(1))
                            phase <= data_phase(plan_q);
                    end
                PH_DATA_OUT, PH_DATA_IN, PH_DONE:
                    phase <= phase; // held until select rises or a warm reset
                default:
                    phase <= PH_STANDBY;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // receive shifter: instruction, address and write data
    // ---------------------------------------------------------------
    logic [BYTE_BITS-1:0] sh_in;
    logic [3:0] bits_in;
    width_t in_w;
    logic in_phase;
    logic [BYTE_BITS-1:0] next_sh_in;
    logic [3:0] next_bits_in;

    // width of the current input phase
    always_comb
    begin
        in_phase = 1'h1;
        case (phase)
            PH_INSTR: in_w = W_SINGLE;
            PH_ADDR: in_w = plan_q.addr_w;
            PH_DATA_IN: in_w = plan_q.data_w;
            default:
            begin
                in_w = W_SINGLE;
                in_phase = 1'h0;
            end
        endcase
        next_sh_in = shift_in(sh_in, d_f, in_w);
        next_bits_in = bits_in + lanes(in_w);
    end

    // shift on each rising clock edge; a full byte is handed over
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sh_in <= '0;
            bits_in <= BITS_NONE;
            instr <= '0;
            instr_valid <= 1'h0;
            rx <= '0;
            rx_valid <= 1'h0;
        end
        else
        begin
            instr_valid <= 1'h0;
            rx_valid <= 1'h0;
            if (phase == PH_STANDBY)
                bits_in <= BITS_NONE;
            else if (rise_ok && in_phase)
            begin
                sh_in <= next_sh_in;
                bits_in <= next_bits_in;
                if (next_bits_in == BYTE_FULL)
                begin
                    bits_in <= BITS_NONE;
                    if (phase == PH_INSTR)
                    begin
                        instr <= next_sh_in;
                        instr_valid <= 1'h1;
                    end
                    else
                    begin
                        rx.data <= next_sh_in;
                        rx.is_addr <= (phase == PH_ADDR);
                        rx_valid <= 1'h1;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit shifter and output drivers
    // ---------------------------------------------------------------
    logic [BYTE_BITS-1:0] sh_out;
    logic [3:0] bits_out;
    logic drv;
    logic load_now;
    logic [BYTE_BITS-1:0] next_sh_out;
    width_t out_w;

    assign out_w = plan_q.data_w;
    // first falling edge after the latency ends, or a spent byte
    assign load_now = !drv || bits_out == BYTE_FULL;

    always_comb
    begin
        if (load_now)
            next_sh_out = tx_data;
        else
            next_sh_out = shift_out(sh_out, out_w);
    end

    // data changes on the falling clock edge of an output phase
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sh_out <= '0;
            bits_out <= BITS_NONE;
            drv <= 1'h0;
            tx_take <= 1'h0;
        end
        else
        begin
            tx_take <= 1'h0;
            if (phase != PH_DATA_OUT)
            begin
                drv <= 1'h0;
                bits_out <= BITS_NONE;
            end
            else if (fall_ok)
            begin
                drv <= 1'h1;
                sh_out <= next_sh_out;
                tx_take <= load_now;
                if (load_now)
                    bits_out <= lanes(out_w);
                else
                    bits_out <= bits_out + lanes(out_w);
            end
        end
    end

    // pin drivers; float outside output phases, on pause and deselect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dq <= '0;
        else
        begin
            dq.out <= out_bits(next_sh_out, out_w);
            if (phase == PH_DATA_OUT && active && !hold_now
                && (drv || fall_ok))
                dq.oe <= oe_mask(out_w);
            else
                dq.oe <= OE_NONE;
            if (!(phase == PH_DATA_OUT && fall_ok))
                dq.out <= out_bits(sh_out, out_w);
        end
    end

    // status flags
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            paused <= 1'h0;
            warm_reset <= 1'h0;
        end
        else
        begin
            paused <= hold_now;
            warm_reset <= warm_now;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_last_latency;
        phase == PH_LATENCY && rise_ok && cnt == CNT_W'(1)
            && plan_q.dir == DIR_OUT;
    endsequence

    sequence s_first_fall;
        phase == PH_DATA_OUT && fall_ok && !drv;
    endsequence

    a_deselect_float: assert property (sel_f |=> dq.oe == OE_NONE)
        else $error("lines driven while deselected");

    a_instr_quiet: assert property (phase == PH_INSTR
        |-> dq.oe == OE_NONE)
        else $error("line driven in instruction phase");

    a_latency_quiet: assert property (phase == PH_LATENCY
        |-> dq.oe == OE_NONE)
        else $error("line driven during latency");

    a_input_quiet: assert property (phase inside {PH_ADDR, PH_DATA_IN}
        |-> dq.oe == OE_NONE)
        else $error("line driven in an input phase");

    a_drive_width: assert property (dq.oe != OE_NONE
        |-> dq.oe == oe_mask(plan_q.data_w))
        else $error("output drive width wrong");

    // the first fall is detected some clocks after the last latency rise
    a_drive_start: assert property (s_last_latency ##[1:16] s_first_fall
        |=> dq.oe == oe_mask(plan_q.data_w) && tx_take)
        else $error("drive did not start at output boundary");

    a_pause_float: assert property (hold_now
        |=> dq.oe == OE_NONE && paused)
        else $error("lines driven during pause");

    a_warm_reset: assert property (warm_now
        |=> warm_reset && phase == PH_STANDBY)
        else $error("warm reset not taken");

    a_quad_reset: assert property (quad_mode && !sel_f
        |=> !warm_reset)
        else $error("warm reset taken while selected in quad mode");

    a_standby_idle: assert property (sel_f && !warm_now
        |=> phase == PH_STANDBY ##1 !instr_valid)
        else $error("activity while deselected");

endmodule : flash_pin_state
`default_nettype wire

// File: tb/spi_host_model.sv
// host bus master model for the serial flash link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
    import flash_pins_pkg::*;
(
    // clock
    input wire logic clk,
    // link pins
    input wire pins_t dq,
    output logic sck,
    output logic select_n,
    output logic [LINES-1:0] lines
);
    // ----------------------------
    // host drivers and wire levels
    // ----------------------------
    logic [3:0] h_out = 4'h0;
    logic [3:0] h_oe = 4'h0;
    logic [3:0] hold_hi = 4'hC; // protect and pause held high
    logic pull3_low = 1'b0;
    logic [3:0] flt = 4'h5;
    int pause_len = 0;
    initial sck = 1'b0;
    initial select_n = 1'b1;

    // released lines change every cycle
    always @(posedge clk)
        flt <= ~flt;

    // resolve each line from both parties' enables
    always_comb
    begin
        for (int i = 0; i < LINES; i++)
            lines[i] = dq.oe[i] ? dq.out[i] : h_oe[i] ? h_out[i] :
                hold_hi[i] ? 1'b1 : flt[i];
        if (pull3_low && !dq.oe[3])
            lines[3] = 1'b0; // reset or pause request
    end

    // ----------------------------
    // bus tasks
    // ----------------------------
    // select change on the next clock, followed by settling time
    task automatic sel(input logic v);
        @(posedge clk);
        select_n <= v;
        repeat (10) @(posedge clk);
    endtask : sel

    // one sck period: lines set while low, sampled at the rise
    task automatic edge_io(input logic [3:0] v, input logic [3:0] oe,
                           output logic [3:0] seen);
        h_out <= v;
        h_oe <= oe;
        repeat (8) @(posedge clk);
        // clock held low for the whole pause
        if (pause_len > 0)
        begin
            pull3_low <= 1'b1;
            repeat (pause_len) @(posedge clk);
            pull3_low <= 1'b0;
            pause_len = 0;
            repeat (8) @(posedge clk);
        end
        seen = lines;
        sck <= 1'b1;
        repeat (8) @(posedge clk);
        sck <= 1'b0;
    endtask : edge_io

    // one byte, msb first, n lines a rise, low bit on line 0
    task automatic xfer(input logic [7:0] tx, input int n,
                        input logic [3:0] oe, input int rd,
                        output logic [7:0] rx);
        logic [3:0] s;
        logic [3:0] m;
        m = 4'((1 << n) - 1);
        rx = 8'h00;
        for (int e = 0; e < 8 / n; e++)
        begin
            edge_io(4'(tx >> (8 - n * (e + 1))) & m, oe, s);
            rx = (rx << n) | 8'((s >> rd) & m);
        end
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: tb/spi_flash_pin_state_control_tb.sv
// self-checking bench for the flash pin-state controller
`timescale 1ns/1ps
`default_nettype none
module spi_flash_pin_state_control_tb
    import flash_pins_pkg::*;
;
    // ----------------------------
    // signals and instances
    // ----------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic quad_mode = 1'b0;
    logic io3_is_reset = 1'b0;
    logic sck, select_n, instr_valid, rx_valid, tx_take, paused, warm_reset;
    logic [7:0] instr, last_instr;
    logic [7:0] tx_data = 8'h00;
    logic [3:0] lines;
    logic [31:0] seed = 32'h00002ADD;
    pins_t dq;
    plan_t plan = '0;
    rx_t rx;
    phase_t phase, prev_ph;
    rx_t got[$];
    rx_t exp_q[$];
    logic [7:0] txq[$];
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int bad_oe = 0;
    int n_instr = 0;

    always #20 clk = ~clk;

    flash_pin_state i_dut (.clk(clk), .rst(rst), .sck(sck),
        .select_n(select_n), .dq_in(lines), .dq(dq), .quad_mode(quad_mode),
        .io3_is_reset(io3_is_reset), .instr(instr),
        .instr_valid(instr_valid), .plan(plan), .rx(rx),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_take(tx_take),
        .phase(phase), .paused(paused), .warm_reset(warm_reset));

    spi_host_model i_host (.clk(clk), .dq(dq), .sck(sck),
        .select_n(select_n), .lines(lines));

    // capture pulses, feed read bytes, count stray drive, cut hangs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        prev_ph <= phase;
        if (instr_valid === 1'b1)
        begin
            last_instr <= instr;
            n_instr <= n_instr + 1;
        end
        if (rx_valid === 1'b1)
            got.push_back(rx);
        if (tx_take === 1'b1 && txq.size() > 0)
            tx_data <= txq.pop_front();
        if (!rst && phase !== PH_DATA_OUT && prev_ph !== PH_DATA_OUT &&
            dq.oe !== OE_NONE)
            bad_oe <= bad_oe + 1;
        if (cycles == 40000)
        begin
            num_errors++;
            final_report();
        end
    end

    // ----------------------------
    // helpers
    // ----------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    function automatic int nl(input width_t w);
        return w == W_DUAL ? 2 : w == W_QUAD ? 4 : 1;
    endfunction : nl

    task automatic check(input logic [31:0] seen, input logic [31:0] want,
                         input string what);
        cmp_count++;
        if (seen !== want)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h",
                $time, what, seen, want);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // one command: instruction, address, latency, data either way
    task automatic run_cmd(input width_t aw, input int na, input int lat,
                           input dir_t d, input width_t dw, input int nd);
        logic [7:0] b, r;
        logic [3:0] s;
        logic [7:0] sent[$];
        got.delete();
        exp_q.delete();
        txq.delete();
        for (int k = 0; k < nd; k++)
            txq.push_back(rnd());
        sent = txq;
        @(posedge clk);
        plan <= '{aw, 6'(na * 8 / nl(aw)), 5'(lat), d, dw};
        tx_data <= txq.pop_front();
        b = rnd();
        i_host.sel(1'b0);
        i_host.xfer(b, 1, 4'h1, 0, r);
        for (int k = 0; k < na; k++)
        begin
            exp_q.push_back('{rnd(), 1'b1});
            i_host.xfer(exp_q[k].data, nl(aw), 4'((1 << nl(aw)) - 1), 0, r);
        end
        repeat (lat) i_host.edge_io(4'h0, 4'h0, s);
        for (int k = 0; k < nd; k++)
            if (d == DIR_IN)
            begin
                exp_q.push_back('{sent[k], 1'b0});
                i_host.xfer(sent[k], nl(dw), 4'((1 << nl(dw)) - 1), 0, r);
            end
            else
            begin
                i_host.xfer(8'h00, nl(dw), 4'h0, dw == W_SINGLE, r);
                check(r, sent[k], "read byte");
            end
        if (d == DIR_OUT)
            check(dq.oe, dw == W_DUAL ? OE_DUAL : dw == W_QUAD ? OE_QUAD :
                OE_SINGLE, "read drive");
        i_host.sel(1'b1);
        check(dq.oe, OE_NONE, "release");
        check(phase, PH_STANDBY, "idle phase");
        check(last_instr, b, "instruction");
        check(got.size(), exp_q.size(), "rx count");
        foreach (exp_q[k])
            check(got[k], exp_q[k], "rx byte");
        check(bad_oe, 0, "stray drive");
        $display("command %0h done", b);
    endtask : run_cmd

    // ----------------------------
    // main sequence
    // ----------------------------
    initial
    begin
        logic [7:0] r;
        int k;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        // line 3 is held high, so either strap must leave commands alone
        r = rnd();
        io3_is_reset <= r[0];
        run_cmd(W_SINGLE, 0, 0, DIR_NONE, W_SINGLE, 0);
        run_cmd(W_SINGLE, 3, 0, DIR_IN, W_SINGLE, 2);
        run_cmd(W_SINGLE, 3, 8, DIR_OUT, W_SINGLE, 2);
        run_cmd(W_DUAL, 3, 1 + rnd() % 4, DIR_OUT, W_DUAL, 1 + rnd() % 3);
        run_cmd(W_DUAL, 1, 0, DIR_IN, W_DUAL, 2);
        // pause needs line 3 configured as the pause input
        io3_is_reset <= 1'b0;
        @(posedge clk);
        // pause in mid read: outputs float, phase kept
        fork
            run_cmd(W_SINGLE, 0, 0, DIR_OUT, W_SINGLE, 2);
            begin
                wait (phase === PH_DATA_OUT);
                repeat (40) @(posedge clk);
                i_host.pause_len = 40;
                wait (i_host.pull3_low === 1'b1);
                repeat (12) @(posedge clk);
                check(paused, 1'b1, "paused");
                check(dq.oe, OE_NONE, "pause float");
                check(phase, PH_DATA_OUT, "pause phase");
            end
        join
        // clocking with select high is ignored
        k = n_instr;
        i_host.xfer(rnd(), 1, 4'h1, 0, r);
        check(n_instr, k, "standby ignore");
        $display("standby test done");
        quad_mode <= 1'b1;
        @(posedge clk);
        i_host.hold_hi <= 4'h0;
        run_cmd(W_QPP, 3, 0, DIR_IN, W_QUAD, 1 + rnd() % 3);
        run_cmd(W_QUAD, 3, 1 + rnd() % 6, DIR_OUT, W_QUAD, 2);
        run_cmd(W_SINGLE, 1, 0, DIR_OUT, W_QUAD, 1);
        // warm reset through line 3 in both modes
        i_host.hold_hi <= 4'h8;
        io3_is_reset <= 1'b1;
        i_host.sel(1'b0);
        i_host.pull3_low <= 1'b1;
        repeat (10) @(posedge clk);
        check(warm_reset, 1'b0, "quad select low");
        i_host.sel(1'b1);
        check(warm_reset, 1'b1, "quad select high");
        i_host.pull3_low <= 1'b0;
        i_host.hold_hi <= 4'hC;
        quad_mode <= 1'b0;
        i_host.sel(1'b0);
        i_host.pull3_low <= 1'b1;
        repeat (10) @(posedge clk);
        check(warm_reset, 1'b1, "line reset");
        check(phase, PH_STANDBY, "reset phase");
        i_host.pull3_low <= 1'b0;
        i_host.sel(1'b1);
        check(warm_reset, 1'b0, "reset gone");
        check(bad_oe, 0, "stray drive");
        $display("warm reset test done");
        final_report();
    end
endmodule : spi_flash_pin_state_control_tb
`default_nettype wire
